// [bench/jtag_debugger_model.sv]
// behavioural debugger on the link side of the security gate
// assumes the bench calls its tasks one at a time; tck runs only inside frames
`timescale 1ns/1ps

module jtag_debugger_model (
  output logic tck_out,
  output logic [2:0] tap_sel_out,
  output logic shift_dr_out,
  output logic update_dr_out,
  output logic tdi_out
);
  // parked clock, data toggles so a stale bit is never mistaken for a live one
  initial begin
    tck_out = 1'b0;
    tap_sel_out = 3'h0;
    shift_dr_out = 1'b0;
    update_dr_out = 1'b0;
    tdi_out = 1'b0;
  end

  // one 32 ns tck period; inputs only move while tck is low
  task automatic tick();
    #16 tck_out = 1'b1;
    #16 tck_out = 1'b0;
  endtask

  // plain tck cycles, no shift, lets the link side leave reset and sync
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      tdi_out = ~tdi_out;
      tick();
    end
  endtask

  // lsb first, 128 shifts then one update on the chosen tap
  task automatic scan_key(input logic [127:0] key, input logic [2:0] tap);
    tap_sel_out = tap;
    shift_dr_out = 1'b1;
    for (int i = 0; i < 128; i++) begin
      tdi_out = key[i];
      tick();
    end
    shift_dr_out = 1'b0;
    update_dr_out = 1'b1;
    tick();
    update_dr_out = 1'b0;
    tap_sel_out = 3'h0;
    tdi_out = ~tdi_out;
    tick();
  endtask

  // park on one tap for n plain cycles, no shift, then deselect
  task automatic hold_tap(input logic [2:0] tap, input int n);
    tap_sel_out = tap;
    idle(n);
    tap_sel_out = 3'h0;
  endtask
endmodule // jtag_debugger_model

// [bench/jtag_security_unlock_tb.sv]
// self-checking bench of the debug-port security gate
// assumes the debugger model drives the link; bench plays the flash
`timescale 1ns/1ps
`include "jtag_security_unlock_consts.svh"

module jtag_security_unlock_tb;
  logic mclk_in, arst_n_in, power_on_reset_n_in, otp_req_out, otp_ack_in, otp_error_in;
  logic [31:0] otp_addr_out;
  logic [127:0] otp_rdata_in;
  logic tck_in, test_tap_sel_in, bscan_sel_in, shift_dr_in, update_dr_in, tdi_in;
  logic [2:0] tap_sel_in;
  logic other_tdo_in, tdo_out, test_tap_enable_out, bscan_enable_out;
  logic [7:0] sec_tap_enable_out;
  logic secured_out, code_invalid_out, code_loaded_out;
  int err_total = 0;
  int n_checks = 0;
  logic [127:0] c1 = ~128'h20; // one code bit cleared

  jtag_security_unlock u_jtag_security_unlock (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .power_on_reset_n_in(power_on_reset_n_in), .otp_req_out(otp_req_out),
    .otp_addr_out(otp_addr_out), .otp_ack_in(otp_ack_in), .otp_error_in(otp_error_in),
    .otp_rdata_in(otp_rdata_in), .tck_in(tck_in), .tap_sel_in(tap_sel_in),
    .test_tap_sel_in(test_tap_sel_in), .bscan_sel_in(bscan_sel_in),
    .shift_dr_in(shift_dr_in), .update_dr_in(update_dr_in), .tdi_in(tdi_in),
    .other_tdo_in(other_tdo_in), .tdo_out(tdo_out), .sec_tap_enable_out(sec_tap_enable_out),
    .test_tap_enable_out(test_tap_enable_out), .bscan_enable_out(bscan_enable_out),
    .secured_out(secured_out), .code_invalid_out(code_invalid_out),
    .code_loaded_out(code_loaded_out));

  jtag_debugger_model u_jtag_debugger_model (.tck_out(tck_in), .tap_sel_out(tap_sel_in),
    .shift_dr_out(shift_dr_in), .update_dr_out(update_dr_in), .tdi_out(tdi_in));

  // 100 MHz system clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait for a flash request, then check where it points
  task automatic wait_req(input int limit);
    int t;
    t = 0;
    while (otp_req_out !== 1'b1 && t < limit) begin
      @(negedge mclk_in);
      t++;
    end
    chk("otp_req", 1'b1, otp_req_out);
    chk("otp_addr", 32'hf000_0000, otp_addr_out);
  endtask

  // answer lands in the wait state, one cycle after the request
  task automatic flash_ack(input logic [127:0] code, input logic err);
    @(negedge mclk_in);
    otp_ack_in = 1'b1;
    otp_error_in = err;
    otp_rdata_in = code;
    @(negedge mclk_in);
    otp_ack_in = 1'b0;
    otp_error_in = 1'b0;
    otp_rdata_in = ~code; // data not held past the strobe
  endtask

  // reset, optional bad first answer, then load and let the link side sync
  task automatic do_reset(input logic por, input logic [127:0] code, input logic bad);
    arst_n_in = 1'b0;
    power_on_reset_n_in = ~por;
    repeat (12) @(negedge mclk_in);
    u_jtag_debugger_model.idle(2);
    @(negedge mclk_in);
    arst_n_in = 1'b1;
    power_on_reset_n_in = 1'b1;
    wait_req(20);
    if (bad) begin
      flash_ack(~code, 1'b1);
      wait_req(4);
    end
    flash_ack(code, 1'b0);
    chk("code_loaded", 1'b1, code_loaded_out);
    u_jtag_debugger_model.idle(8);
    repeat (8) @(negedge mclk_in);
  endtask

  task automatic check_lock(input logic locked);
    chk("secured", locked, secured_out);
    chk("sec_taps", locked ? 8'h04 : 8'hff, sec_tap_enable_out);
    chk("test_tap", !locked, test_tap_enable_out);
    chk("bscan", !locked, bscan_enable_out);
  endtask

  // scan, then give secured_out its three mclk cycles and some margin
  task automatic scan(input logic [127:0] key, input logic [2:0] tap);
    u_jtag_debugger_model.scan_key(key, tap);
    repeat (6) @(negedge mclk_in);
  endtask

  // shipped code with cleared key opens, even after a bad flash answer
  task automatic test_shipped();
    do_reset(1'b1, ~128'h0, 1'b1);
    check_lock(1'b0);
    chk("invalid", 1'b0, code_invalid_out);
  endtask

  // one cleared bit locks; only tap 2 and the exact key open it
  task automatic test_secure_unlock();
    do_reset(1'b1, c1, 1'b0);
    check_lock(1'b1);
    other_tdo_in = 1'b1;
    u_jtag_debugger_model.idle(2);
    chk("tdo_locked", 1'b0, tdo_out);
    scan(~c1, 3'h1);
    check_lock(1'b1);
    test_tap_sel_in = 1'b1;
    scan(~c1, 3'h2);
    test_tap_sel_in = 1'b0;
    bscan_sel_in = 1'b1;
    scan(~c1, 3'h2);
    bscan_sel_in = 1'b0;
    check_lock(1'b1);
    scan(~c1 ^ 128'h1, 3'h2);
    check_lock(1'b1);
    scan(~c1, 3'h2);
    check_lock(1'b0);
    u_jtag_debugger_model.idle(2);
    chk("tdo_open", 1'b1, tdo_out);
    u_jtag_debugger_model.hold_tap(3'h2, 2);
    chk("tdo_chain", 1'b0, tdo_out);
  endtask

  // system reset keeps the key, power-on reset alone clears it
  task automatic test_key_reset();
    do_reset(1'b0, c1, 1'b0);
    check_lock(1'b0);
    power_on_reset_n_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    power_on_reset_n_in = 1'b1;
    repeat (6) @(negedge mclk_in);
    check_lock(1'b1);
  endtask

  // all-zero code stays locked even with a key that would match
  task automatic test_all_zero();
    do_reset(1'b1, 128'h0, 1'b0);
    chk("invalid", 1'b1, code_invalid_out);
    scan(~128'h0, 3'h2);
    check_lock(1'b1);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence; inputs move on falling mclk edges
  initial begin
    arst_n_in = 1'b0;
    power_on_reset_n_in = 1'b0;
    otp_ack_in = 1'b0;
    otp_error_in = 1'b0;
    otp_rdata_in = 128'h0;
    test_tap_sel_in = 1'b0;
    bscan_sel_in = 1'b0;
    other_tdo_in = 1'b0;
    test_shipped();
    test_secure_unlock();
    test_key_reset();
    test_all_zero();
    summarize();
  end

  // hang guard, well past the roughly 28 us the tests need
  initial begin
    #300000;
    err_total++;
    summarize();
  end
endmodule // jtag_security_unlock_tb

// [src/jtag_security_unlock.sv]
// debug-port security gate: visible code load, key compare, tap gating
// assumes a flash read port on mclk_in and router strobes on tck_in
//
// Summary of operation
// R1: read the 128-bit visible code at 0xf0000000; erased code leaves device open.
// R2: xor every code bit with the matching scan key bit.
// R3: mix the xor vector with hidden tie-offs before comparing.
// R4: exact match against hidden constant asserts release, device becomes open.
// R5: code bits only fall from one to zero; any zero bit secures.
// R6: an all-zero code is invalid and keeps the device locked forever.
// R7: debugger scans a key whose xor with the code gives the shipped code.
// R8: only power-on reset clears the scan key register.
// R9: while locked, the security chain is reached through secondary tap 2 only.
// R10: while locked, other secondary taps, test taps and boundary scan are blocked.
// R11: release reopens every tap at once, following the key combinationally.
`timescale 1ns/1ps
`include "jtag_security_unlock_consts.svh"

module jtag_security_unlock (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic power_on_reset_n_in,
  output logic otp_req_out,
  output logic [31:0] otp_addr_out,
  input wire logic otp_ack_in,
  input wire logic otp_error_in,
  input wire logic [`KEY_WIDTH-1:0] otp_rdata_in,
  input wire logic tck_in,
  input wire logic [2:0] tap_sel_in,
  input wire logic test_tap_sel_in,
  input wire logic bscan_sel_in,
  input wire logic shift_dr_in,
  input wire logic update_dr_in,
  input wire logic tdi_in,
  input wire logic other_tdo_in,
  output logic tdo_out,
  output logic [`SEC_TAP_COUNT-1:0] sec_tap_enable_out,
  output logic test_tap_enable_out,
  output logic bscan_enable_out,
  output logic secured_out,
  output logic code_invalid_out,
  output logic code_loaded_out
);

  // the compare: xor, tie-off mix, exact match, zero code never passes
  function automatic logic release_eval(input logic [`KEY_WIDTH-1:0] code,
                                        input logic [`KEY_WIDTH-1:0] key);
    logic [`KEY_WIDTH-1:0] mixed;
    mixed = (code ^ key) ^ `TIE_OFF; // [R2] [R3]
    release_eval = (code != `CODE_ZERO) && (mixed == `HIDDEN_VALUE); // [R4] [R6]
  endfunction

  // mclk domain: visible code fetch
  jtag_security_unlock_pkg::load_state_type state;
  jtag_security_unlock_pkg::load_state_type next_state;
  logic [`KEY_WIDTH-1:0] code;
  logic [`KEY_WIDTH-1:0] next_code;
  logic [7:0] wait_count;
  logic [7:0] next_wait_count;

  // mclk domain: status
  logic release_meta;
  logic release_sync;
  logic secured;
  logic next_secured;
  logic code_invalid;
  logic next_code_invalid;
  logic loaded;
  logic next_loaded;

  // tck domain
  logic tck_rst_meta;
  logic tck_rst_n;
  logic loaded_meta;
  logic loaded_sync;
  logic [`KEY_WIDTH-1:0] code_tck;
  logic [`KEY_WIDTH-1:0] next_code_tck;
  logic code_valid;
  logic next_code_valid;
  logic tdo;
  logic next_tdo;
  logic [`KEY_WIDTH-1:0] key;
  logic key_scan_bit;
  logic chain_sel;
  logic release_tck;

  // fetch sequence: one-cycle request, wait for answer, retry on error or timeout
  always_comb begin
    next_state = state;
    next_code = code;
    next_wait_count = wait_count;
    case (state)
      jtag_security_unlock_pkg::load_idle: begin
        next_state = jtag_security_unlock_pkg::load_req;
      end
      jtag_security_unlock_pkg::load_req: begin
        next_wait_count = 8'h00;
        next_state = jtag_security_unlock_pkg::load_wait;
      end
      jtag_security_unlock_pkg::load_wait: begin
        if (otp_ack_in) begin
          if (otp_error_in) begin
            next_state = jtag_security_unlock_pkg::load_req;
          end else begin
            // and-ing keeps the copy from regaining a cleared bit until the next system reset
            next_code = code & otp_rdata_in; // [R5]
            next_state = jtag_security_unlock_pkg::load_done;
          end
        end else if (wait_count == `OTP_TIMEOUT) begin
          next_state = jtag_security_unlock_pkg::load_req;
        end else begin
          next_wait_count = wait_count + 8'h01;
        end
      end
      jtag_security_unlock_pkg::load_done: begin
        next_state = jtag_security_unlock_pkg::load_done;
      end
      default: begin
        next_state = jtag_security_unlock_pkg::load_idle;
      end
    endcase
  end

  // code copy starts erased so the first read lands unchanged
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= jtag_security_unlock_pkg::load_idle;
      code <= `SHIPPED_CODE;
      wait_count <= 8'h00;
    end else begin
      state <= next_state;
      code <= next_code;
      wait_count <= next_wait_count;
    end
  end

  // request strobe and fixed code address
  assign otp_req_out = (state == jtag_security_unlock_pkg::load_req); // [R1]
  assign otp_addr_out = `OTP_CODE_ADDR; // [R1]

  // release brought over from the link clock, first stage read only by second
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      release_meta <= 1'b0;
      release_sync <= 1'b0;
    end else begin
      release_meta <= release_tck;
      release_sync <= release_meta;
    end
  end

  // status seen by the system side
  always_comb begin
    next_secured = !release_sync;
    next_code_invalid = (state == jtag_security_unlock_pkg::load_done)
                        && (code == `CODE_ZERO); // [R6]
    next_loaded = (next_state == jtag_security_unlock_pkg::load_done);
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      secured <= 1'b1;
      code_invalid <= 1'b0;
      loaded <= 1'b0;
    end else begin
      secured <= next_secured;
      code_invalid <= next_code_invalid;
      loaded <= next_loaded;
    end
  end

  assign secured_out = secured;
  assign code_invalid_out = code_invalid;
  assign code_loaded_out = loaded; // a flop: the link side syncs it, a decode could glitch

  // link-side reset: asserts at once, releases on the link clock
  always_ff @(posedge tck_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tck_rst_meta <= 1'b0;
      tck_rst_n <= 1'b0;
    end else begin
      tck_rst_meta <= 1'b1;
      tck_rst_n <= tck_rst_meta;
    end
  end

  // loaded level crosses; the code word is stable once it is set
  always_ff @(posedge tck_in or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      loaded_meta <= 1'b0;
      loaded_sync <= 1'b0;
    end else begin
      loaded_meta <= code_loaded_out;
      loaded_sync <= loaded_meta;
    end
  end

  // chain reached only through the one secondary tap
  assign chain_sel = (tap_sel_in == `UNLOCK_TAP_NUM) && !test_tap_sel_in
                     && !bscan_sel_in; // [R9]

  scan_key_store key_store (
    .tck_in(tck_in),
    .power_on_reset_n_in(power_on_reset_n_in),
    .shift_en_in(shift_dr_in && chain_sel),
    .update_en_in(update_dr_in && chain_sel),
    .tdi_in(tdi_in),
    .key_out(key),
    .scan_bit_out(key_scan_bit)
  );

  // capture the code copy once; until then the gate stays shut
  always_comb begin
    next_code_tck = code_tck;
    next_code_valid = code_valid;
    if (loaded_sync && !code_valid) begin
      next_code_tck = code;
      next_code_valid = 1'b1;
    end
  end

  // tdo: chain bit, other taps only once released
  always_comb begin
    if (chain_sel) begin
      next_tdo = key_scan_bit; // [R9]
    end else if (release_tck) begin
      next_tdo = other_tdo_in; // [R11]
    end else begin
      next_tdo = 1'b0; // [R10]
    end
  end

  always_ff @(posedge tck_in or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      code_tck <= `CODE_ZERO;
      code_valid <= 1'b0;
      tdo <= 1'b0;
    end else begin
      code_tck <= next_code_tck;
      code_valid <= next_code_valid;
      tdo <= next_tdo;
    end
  end

  assign tdo_out = tdo;

  // no flop in the path: a fresh key opens the taps immediately
  assign release_tck = code_valid && release_eval(code_tck, key); // [R4] [R11]

  // tap gating; the chain's own tap is never closed
  always_comb begin
    for (int i = 0; i < `SEC_TAP_COUNT; i++) begin
      sec_tap_enable_out[i] = release_tck; // [R10] [R11]
    end
    sec_tap_enable_out[`UNLOCK_TAP_NUM] = 1'b1; // [R9]
    test_tap_enable_out = release_tck; // [R10] [R11]
    bscan_enable_out = release_tck; // [R10] [R11]
  end

  otp_fetch_a: assert property ( // [R1]
    @(posedge mclk_in) disable iff (!arst_n_in)
    $fell(arst_n_in) or (state == jtag_security_unlock_pkg::load_idle)
    |=> otp_req_out && otp_addr_out == `OTP_CODE_ADDR)
    else $error("code fetch not issued after idle");

  shipped_open_a: assert property ( // [R1]
    @(posedge tck_in) disable iff (!tck_rst_n)
    code_valid && code_tck == `SHIPPED_CODE && key == `CODE_ZERO
    |-> release_tck && test_tap_enable_out)
    else $error("erased code did not leave device open");

  xor_key_a: assert property ( // [R2]
    @(posedge tck_in) disable iff (!tck_rst_n)
    code_valid && code_tck != `CODE_ZERO && key == ~code_tck
    |-> release_tck)
    else $error("inverse key failed to release");

  tie_offs_a: assert property ( // [R3]
    @(posedge tck_in) disable iff (!tck_rst_n)
    release_tck |-> (code_tck ^ key) != `HIDDEN_VALUE)
    else $error("release without tie-off mixing");

  code_monotone_a: assert property ( // [R5]
    @(posedge mclk_in) disable iff (!arst_n_in)
    ##1 (code & ~$past(code)) == `CODE_ZERO)
    else $error("code copy regained a cleared bit");

  zero_code_a: assert property ( // [R6]
    @(posedge tck_in) disable iff (!tck_rst_n)
    code_tck == `CODE_ZERO |-> !release_tck && !bscan_enable_out)
    else $error("all-zero code released the device");

  chain_tap_a: assert property ( // [R9]
    @(posedge tck_in) disable iff (!tck_rst_n)
    !release_tck && chain_sel ##1 !chain_sel |-> tdo_out == $past(key_scan_bit))
    else $error("chain bit not on tdo through its tap");

  locked_gate_a: assert property ( // [R10]
    @(posedge tck_in) disable iff (!tck_rst_n)
    !release_tck |-> sec_tap_enable_out == `SEC_TAP_COUNT'(1 << `UNLOCK_TAP_NUM)
    && !test_tap_enable_out && !bscan_enable_out)
    else $error("tap open while locked");

  locked_tdo_a: assert property ( // [R10]
    @(posedge tck_in) disable iff (!tck_rst_n)
    !release_tck && !chain_sel |=> !tdo_out)
    else $error("foreign tdo leaked while locked");

  release_open_a: assert property ( // [R11]
    @(posedge tck_in) disable iff (!tck_rst_n)
    release_tck |-> &sec_tap_enable_out && test_tap_enable_out
    && bscan_enable_out)
    else $error("release did not reopen all taps");

  status_sync_a: assert property ( // [R11]
    @(posedge mclk_in) disable iff (!arst_n_in)
    $rose(release_sync) |=> !secured_out)
    else $error("secured status did not follow release");

endmodule // jtag_security_unlock

// [src/jtag_security_unlock_consts.svh]
// constants of the debug-port security gate: widths, addresses, tap numbers
// assumes inclusion by bare name from the design files and the bench
`ifndef JTAG_SECURITY_UNLOCK_CONSTS_SVH
`define JTAG_SECURITY_UNLOCK_CONSTS_SVH

// visible code and key width
`define KEY_WIDTH 128
// flash location of the visible code
`define OTP_CODE_ADDR 32'hf000_0000
// secondary tap that reaches the security chain
`define UNLOCK_TAP_NUM 3'h2
// number of secondary taps behind the router
`define SEC_TAP_COUNT 8
// erased flash state of the visible code
`define SHIPPED_CODE 128'hffff_ffff_ffff_ffff_ffff_ffff_ffff_ffff
// all-zero visible code
`define CODE_ZERO 128'h0
// internal tie-off pattern, arbitrary
`define TIE_OFF 128'h5a3c_96e1_0f87_2d4b_c3a5_69f0_1e78_b4d2
// hard-wired compare value, shipped code with zero key matches
`define HIDDEN_VALUE (`SHIPPED_CODE ^ `TIE_OFF)
// cycles to wait for a flash answer before asking again
`define OTP_TIMEOUT 8'hff

`endif

// [src/jtag_security_unlock_pkg.sv]
// types of the debug-port security gate
// assumes the constants header is included where numbers are needed
package jtag_security_unlock_pkg;

  // load sequence of the visible code
  typedef enum logic [1:0] {
    load_idle,
    load_req,
    load_wait,
    load_done
  } load_state_type;

endpackage

// [src/scan_key_store.sv]
// scan key register: shift stage plus held key, on the link clock
// assumes shift and update strobes already qualified by tap selection
`timescale 1ns/1ps
`include "jtag_security_unlock_consts.svh"

module scan_key_store (
  input wire logic tck_in,
  input wire logic power_on_reset_n_in,
  input wire logic shift_en_in,
  input wire logic update_en_in,
  input wire logic tdi_in,
  output logic [`KEY_WIDTH-1:0] key_out,
  output logic scan_bit_out
);

  logic [`KEY_WIDTH-1:0] shift_reg;
  logic [`KEY_WIDTH-1:0] key;
  logic [`KEY_WIDTH-1:0] next_shift_reg;
  logic [`KEY_WIDTH-1:0] next_key;

  // shift lsb first, key loads from the shift stage on update
  always_comb begin
    next_shift_reg = shift_reg;
    next_key = key;
    if (shift_en_in) begin
      next_shift_reg = {tdi_in, shift_reg[`KEY_WIDTH-1:1]};
    end
    if (update_en_in) begin
      next_key = shift_reg;
    end
  end

  // only power-on reset clears; system resets must not drop a scanned key
  always_ff @(posedge tck_in or negedge power_on_reset_n_in) begin
    if (!power_on_reset_n_in) begin // [R8]
      shift_reg <= `CODE_ZERO;
      key <= `CODE_ZERO;
    end else begin
      shift_reg <= next_shift_reg;
      key <= next_key;
    end
  end

  assign key_out = key;
  assign scan_bit_out = shift_reg[0];

  key_hold_a: assert property ( // [R8]
    @(posedge tck_in) disable iff (!power_on_reset_n_in)
    !update_en_in |=> $stable(key))
    else $error("key changed without an update");

  key_load_a: assert property ( // [R8]
    @(posedge tck_in) disable iff (!power_on_reset_n_in)
    update_en_in |=> key == $past(shift_reg))
    else $error("key did not take the shift stage");

endmodule // scan_key_store
